/* File: rtl/rtc_minute_irq.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"

// Behaviour
// - In minute mode 1 a pin carries a one-minute square wave at half duty, starting at the first carry.
// - Disabling minute mode 1 while the pin is low releases it at once, and re-enabling within the same low phase drives it low again.
// - Minute mode 2 exists only on the primary pin and pulls it low 7.81 ms from each minute carry.
// - While time is being read the minute carry, and the mode 2 pulse with it, waits at most 0.5 s.
// - Writing the time may shift the mode 2 pulse, depending on the moment and seconds value written.
// - Power-up detection sets the power-up flag in bit 0 of status register 1.
// - While the power-up flag is set the primary pin carries a 1 Hz clock.
// - Rate correction alters the pulse count of one divider stage and never touches the oscillator.
// - One correction is applied per interval of 20 s with trim bit 0 clear and 60 s with it set.
// - One step is 3.052 ppm at the 20 s interval and 1.017 ppm at the 60 s interval.
// - The reach is -195.3 to +192.3 ppm at 20 s and -65.1 to +64.1 ppm at 60 s.
// - A trim value of 00h gives no correction and is what the host writes to disable it.
// - Trim bits 7 to 1 hold the 7-bit step count reversed, bit 7 being its least significant bit.
// - The step count is two's complement: 1 to 63 speed up, 64 to 127 slow down, 127 being one step.
module rtc_minute_irq
   import rtc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic osc_32k_in,
   input wire host_req_t host_req_in,
   input wire logic irq_pin_primary_in,
   output logic irq_pin_primary_out,
   output logic irq_pin_primary_oe_out,
   input wire logic irq_pin_secondary_in,
   output logic irq_pin_secondary_out,
   output logic irq_pin_secondary_oe_out,
   output logic [7:0] trim_out,
   output logic [7:0] status1_out,
   output logic [7:0] status2_out,
   output logic [5:0] seconds_out,
   output logic [1:0] pin_level_out,
   output logic power_up_flag_out
);

   // oscillator and pin synchronisers
   logic osc_meta_q;
   logic osc_sync_q;
   logic osc_prev_q;
   logic osc_edge;
   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_q;

   // registers
   logic [7:0] clock_rate_trim_q;
   logic [7:0] st2_q;
   logic power_up_flag_q;

   // timekeeping
   tick_bus_t ticks;
   logic restart;
   logic [5:0] sec_q;
   logic carry_pend_q;
   logic [13:0] hold_cnt_q;
   logic carry;
   logic hold_expired;

   // pin modes
   logic [1:0] m1_en;
   logic [1:0] m1_phase_low_q;
   logic [1:0] m1_started_q;
   logic m2_en;
   logic [7:0] m2_cnt_q;
   logic primary_low_d;
   logic secondary_low_d;

   logic wr_status1;
   logic wr_status2;
   logic wr_trim;
   logic wr_seconds;

   // out-of-range seconds fall back to zero
   function automatic logic [5:0] clean_seconds(input logic [7:0] value);
      return (value > {2'b00, `RTC_LAST_SECOND}) ? 6'h00 : value[5:0];
   endfunction

   // a mode 1 pin pulls low only once its wave has started
   function automatic logic m1_low(input logic en, input logic started, input logic phase_low);
      return en & started & phase_low;
   endfunction

   assign wr_status1 = host_req_in.wr & (host_req_in.sel == SEL_STATUS1);
   assign wr_status2 = host_req_in.wr & (host_req_in.sel == SEL_STATUS2);
   assign wr_trim = host_req_in.wr & (host_req_in.sel == SEL_TRIM);
   assign wr_seconds = host_req_in.wr & (host_req_in.sel == SEL_SECONDS);

   // only the synchronised copy feeds the edge detector
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_meta_q <= osc_32k_in;
         osc_sync_q <= osc_meta_q;
         osc_prev_q <= osc_sync_q;
      end
   end

   assign osc_edge = osc_sync_q & ~osc_prev_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta_q <= 2'b11;
         pin_sync_q <= 2'b11;
      end else begin
         pin_meta_q <= {irq_pin_secondary_in, irq_pin_primary_in};
         pin_sync_q <= pin_meta_q;
      end
   end

   // reset release stands for power-up detection; any status 1 write clears the flag
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_up_flag_q <= 1'b1;
      end else if (wr_status1) begin
         power_up_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st2_q <= `RTC_ST2_RESET;
      end else if (wr_status2) begin
         st2_q <= host_req_in.data;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clock_rate_trim_q <= `RTC_TRIM_RESET;
      end else if (wr_trim) begin
         clock_rate_trim_q <= host_req_in.data;
      end
   end

   // a seconds write restarts the sub-second chain, moving every later carry
   assign restart = wr_seconds;

   trim_divider u_trim_divider (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .osc_edge_in(osc_edge),
      .trim_in(clock_rate_trim_q),
      .restart_in(restart),
      .ticks_out(ticks)
   );

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sec_q <= 6'h00;
      end else if (wr_seconds) begin
         sec_q <= clean_seconds(host_req_in.data);
      end else if (ticks.sec_tick) begin
         sec_q <= (sec_q == `RTC_LAST_SECOND) ? 6'h00 : sec_q + 6'h01;
      end
   end

   // a read in progress parks the carry, but never past the hold limit
   assign hold_expired = (hold_cnt_q >= 14'(`RTC_HOLD_MAX_TICKS));
   assign carry = carry_pend_q & (~host_req_in.time_rd_busy | hold_expired);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         carry_pend_q <= 1'b0;
      end else if (wr_seconds) begin
         carry_pend_q <= 1'b0;
      end else if (ticks.sec_tick && sec_q == `RTC_LAST_SECOND) begin
         carry_pend_q <= 1'b1;
      end else if (carry) begin
         carry_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_cnt_q <= 14'h0000;
      end else if (!carry_pend_q || carry) begin
         hold_cnt_q <= 14'h0000;
      end else if (ticks.stage_tick && !hold_expired) begin
         hold_cnt_q <= hold_cnt_q + 14'h0001;
      end
   end

   assign m1_en = {st2_q[`RTC_ST2_M1_SECONDARY_BIT], st2_q[`RTC_ST2_M1_PRIMARY_BIT]};
   // mode 2 has no secondary-pin variant
   assign m2_en = st2_q[`RTC_ST2_M2_PRIMARY_BIT];

   // the wave phase keeps running while disabled so a re-enable lands on the right level
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m1_phase_low_q <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (carry) begin
               m1_phase_low_q[i] <= 1'b1;
            end else if (ticks.sec_tick && sec_q == `RTC_HALF_MINUTE_SECOND - 6'h01) begin
               m1_phase_low_q[i] <= 1'b0;
            end
         end
      end
   end

   // started survives a disable in the low phase, so a re-enable pulls low again
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m1_started_q <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (carry && m1_en[i]) begin
               m1_started_q[i] <= 1'b1;
            end else if (!m1_en[i] && !m1_phase_low_q[i]) begin
               m1_started_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         m2_cnt_q <= 8'h00;
      end else if (!m2_en) begin
         m2_cnt_q <= 8'h00;
      end else if (carry) begin
         m2_cnt_q <= 8'(`RTC_M2_LOW_TICKS);
      end else if (ticks.stage_tick && m2_cnt_q != 8'h00) begin
         m2_cnt_q <= m2_cnt_q - 8'h01;
      end
   end

   // power-up clock outranks every selected mode on the primary pin
   always_comb begin
      if (power_up_flag_q) begin
         primary_low_d = ticks.half_low;
      end else if (m2_en) begin
         primary_low_d = (m2_cnt_q != 8'h00);
      end else begin
         primary_low_d = m1_low(m1_en[0], m1_started_q[0], m1_phase_low_q[0]);
      end
      secondary_low_d = m1_low(m1_en[1], m1_started_q[1], m1_phase_low_q[1]);
   end

   // open drain: level is always low, the enable does the signalling
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_pin_primary_out <= 1'b0;
         irq_pin_primary_oe_out <= 1'b0;
      end else begin
         irq_pin_primary_out <= 1'b0;
         irq_pin_primary_oe_out <= primary_low_d;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_pin_secondary_out <= 1'b0;
         irq_pin_secondary_oe_out <= 1'b0;
      end else begin
         irq_pin_secondary_out <= 1'b0;
         irq_pin_secondary_oe_out <= secondary_low_d;
      end
   end

   // readback copies lag their registers by one cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trim_out <= `RTC_TRIM_RESET;
         status2_out <= `RTC_ST2_RESET;
      end else begin
         trim_out <= clock_rate_trim_q;
         status2_out <= st2_q;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status1_out <= 8'h00;
         power_up_flag_out <= 1'b0;
      end else begin
         status1_out <= 8'h00;
         status1_out[`RTC_ST1_POWER_UP_BIT] <= power_up_flag_q;
         power_up_flag_out <= power_up_flag_q;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seconds_out <= 6'h00;
         pin_level_out <= 2'b11;
      end else begin
         seconds_out <= sec_q;
         pin_level_out <= pin_sync_q;
      end
   end

endmodule

`default_nettype wire

/* File: rtl/rtc_params.svh */
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// oscillator and divider stage rates, in Hz
`define RTC_OSC_HZ 32768
`define RTC_STAGE_HZ 16384
// stage counter is biased so that negative trims fit without wrapping
`define RTC_TRIM_BIAS 17'h00040
`define RTC_STAGE_TOP (`RTC_TRIM_BIAS + 17'h03FFF)
`define RTC_STAGE_HALF (`RTC_TRIM_BIAS + 17'h02000)

// correction intervals in seconds
`define RTC_INTERVAL_SHORT_S 6'h14
`define RTC_INTERVAL_LONG_S 6'h3C

// calendar figures
`define RTC_LAST_SECOND 6'h3B
`define RTC_HALF_MINUTE_SECOND 6'h1E

// minute-periodical mode 2 low time, least time rounds up
`define RTC_M2_LOW_US 7810
`define RTC_M2_LOW_TICKS ((`RTC_M2_LOW_US * `RTC_STAGE_HZ + 999999) / 1000000)

// longest hold-off of the minute carry while time is read, rounds down
`define RTC_HOLD_MAX_MS 500
`define RTC_HOLD_MAX_TICKS ((`RTC_HOLD_MAX_MS * `RTC_STAGE_HZ) / 1000)

// register field positions
`define RTC_ST1_POWER_UP_BIT 0
`define RTC_ST2_M1_PRIMARY_BIT 0
`define RTC_ST2_M2_PRIMARY_BIT 1
`define RTC_ST2_M1_SECONDARY_BIT 2
`define RTC_TRIM_INTERVAL_BIT 0

// reset values
`define RTC_TRIM_RESET 8'h00
`define RTC_ST2_RESET 8'h00

`endif

/* File: rtl/rtc_pkg.sv */
package rtc_pkg;

   typedef enum logic [1:0] {
      SEL_STATUS1,
      SEL_STATUS2,
      SEL_TRIM,
      SEL_SECONDS
   } reg_sel_t;

   // one register write per cycle from the serial front end, plus its read activity
   typedef struct packed {
      logic wr;
      reg_sel_t sel;
      logic [7:0] data;
      logic time_rd_busy;
   } host_req_t;

   typedef struct packed {
      logic sec_tick;
      logic stage_tick;
      logic half_low;
   } tick_bus_t;

endpackage

/* File: rtl/trim_divider.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"

module trim_divider
   import rtc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic osc_edge_in,
   input wire logic [7:0] trim_in,
   input wire logic restart_in,
   output tick_bus_t ticks_out
);

   logic pre_q;
   logic [16:0] count_q;
   logic [5:0] interval_q;
   logic stage_tick;
   logic interval_end;
   logic [5:0] interval_last;

   // reversed, two's complement step count; 00h yields zero steps
   function automatic logic [16:0] trim_load(input logic [7:0] code);
      logic [6:0] steps;
      steps = {code[1], code[2], code[3], code[4], code[5], code[6], code[7]};
      return `RTC_TRIM_BIAS + {{10{steps[6]}}, steps};
   endfunction

   // the 16384 Hz stage is the one whose pulse count is trimmed
   assign stage_tick = osc_edge_in & pre_q;
   assign interval_last = trim_in[`RTC_TRIM_INTERVAL_BIT] ?
      (`RTC_INTERVAL_LONG_S - 6'h01) : (`RTC_INTERVAL_SHORT_S - 6'h01);
   assign interval_end = (interval_q >= interval_last);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre_q <= 1'b0;
      end else if (restart_in) begin
         pre_q <= 1'b0;
      end else if (osc_edge_in) begin
         pre_q <= ~pre_q;
      end
   end

   // positive steps shorten one second per interval, negative ones lengthen it
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_q <= `RTC_TRIM_BIAS;
         interval_q <= 6'h00;
      end else if (restart_in) begin
         count_q <= `RTC_TRIM_BIAS;
         interval_q <= 6'h00;
      end else if (stage_tick) begin
         if (count_q >= `RTC_STAGE_TOP) begin
            if (interval_end) begin
               interval_q <= 6'h00;
               count_q <= trim_load(trim_in);
            end else begin
               interval_q <= interval_q + 6'h01;
               count_q <= `RTC_TRIM_BIAS;
            end
         end else begin
            count_q <= count_q + 17'h00001;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ticks_out <= '0;
      end else begin
         ticks_out.stage_tick <= stage_tick & ~restart_in;
         ticks_out.sec_tick <= stage_tick & ~restart_in & (count_q >= `RTC_STAGE_TOP);
         ticks_out.half_low <= (count_q >= `RTC_STAGE_HALF);
      end
   end

endmodule

`default_nettype wire

/* File: tb/rtc_minute_irq_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module rtc_minute_irq_asserts
   import rtc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire host_req_t host_req_in,
   input wire logic irq_pin_primary_out,
   input wire logic irq_pin_primary_oe_out,
   input wire logic irq_pin_secondary_out,
   input wire logic irq_pin_secondary_oe_out,
   input wire logic [7:0] trim_out,
   input wire logic [7:0] status1_out,
   input wire logic [7:0] status2_out,
   input wire logic [5:0] seconds_out,
   input wire logic power_up_flag_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   trim_write_a: assert property (host_req_in.wr && host_req_in.sel == SEL_TRIM
      |-> ##2 trim_out == $past(host_req_in.data, 2)) else $error("trim readback wrong");
   mode_write_a: assert property (host_req_in.wr && host_req_in.sel == SEL_STATUS2
      |-> ##2 status2_out == $past(host_req_in.data, 2)) else $error("mode readback wrong");
   flag_clear_a: assert property (host_req_in.wr && host_req_in.sel == SEL_STATUS1
      |-> ##2 !power_up_flag_out && status1_out == 8'h00) else $error("flag not cleared");
   status_mirror_a: assert property (status1_out == {7'h00, power_up_flag_out})
      else $error("status1 does not mirror flag");
   open_drain_a: assert property (!irq_pin_primary_out && !irq_pin_secondary_out)
      else $error("pin driven high");
   mode_release_a: assert property ($fell(status2_out[2]) |-> ##[0:2] !irq_pin_secondary_oe_out)
      else $error("secondary not released");
   first_half_a: assert property ($rose(power_up_flag_out) |-> !irq_pin_primary_oe_out [*8])
      else $error("primary low too early");
   sec_range_a: assert property (seconds_out <= 6'h3B)
      else $error("seconds out of range");
   sec_invalid_a: assert property (host_req_in.wr && host_req_in.sel == SEL_SECONDS
      && host_req_in.data > 8'h3B |-> ##2 seconds_out == 6'h00) else $error("bad seconds kept");
endmodule
bind rtc_minute_irq rtc_minute_irq_asserts chk (.clk_sys_in, .rst_n_in, .host_req_in,
   .irq_pin_primary_out, .irq_pin_primary_oe_out, .irq_pin_secondary_out, .irq_pin_secondary_oe_out,
   .trim_out, .status1_out, .status2_out, .seconds_out, .power_up_flag_out);
`default_nettype wire

/* File: tb/rtc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model
   import rtc_pkg::*;
(
   input wire logic clk_sys_in,
   output host_req_t req_out
);
   initial req_out = '0;
   // changes land at the falling edge, held across the taking edge
   task automatic write_reg(input reg_sel_t sel, input logic [7:0] data);
      @(negedge clk_sys_in);
      req_out.sel = sel;
      req_out.data = data;
      req_out.wr = 1'b1;
      @(negedge clk_sys_in);
      req_out.wr = 1'b0;
   endtask
   task automatic set_busy(input logic busy);
      @(negedge clk_sys_in);
      req_out.time_rd_busy = busy;
   endtask
   function automatic logic [7:0] pack_trim(input logic [6:0] code, input logic long_iv);
      logic [7:0] t;
      for (int i = 0; i < 7; i++) t[7 - i] = code[i];
      t[0] = long_iv;
      return t;
   endfunction
   // n of 0 gives zero steps, the no-correction code: 00h, or 01h with long_iv set
   function automatic logic [7:0] trim_fast(input int n, input logic long_iv);
      return pack_trim(7'((128 - n) % 128), long_iv);
   endfunction
   function automatic logic [7:0] trim_slow(input int n, input logic long_iv);
      return pack_trim(7'(n + 1), long_iv);
   endfunction
endmodule
`default_nettype wire

/* File: tb/rtc_minute_irq_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module rtc_minute_irq_tb
   import rtc_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic osc_32k_in = 1'b0;
   host_req_t host_req;
   logic p_out, p_oe, s_out, s_oe, flag;
   logic [7:0] trim, st1, st2;
   logic [5:0] secs;
   logic [1:0] lvl;
   int n_fail = 0;
   int num_checks = 0;
   int cnt;
   logic [7:0] codes [7] = '{8'h56, 8'hD8, 8'hFC, 8'h02, 8'hFD, 8'h03, 8'h00};
   // pull-ups: a released pin reads high
   wire logic p_pin = !p_oe;
   wire logic s_pin = !s_oe;
   initial forever #4 clk_sys_in = ~clk_sys_in;
   // oscillator at half the clock rate: one second is 65536 clocks, so a minute carry fits the run
   initial forever #8 osc_32k_in = ~osc_32k_in;
   rtc_host_model host (.clk_sys_in, .req_out(host_req));
   rtc_minute_irq dut (.clk_sys_in, .rst_n_in, .osc_32k_in, .host_req_in(host_req),
      .irq_pin_primary_in(p_pin), .irq_pin_primary_out(p_out), .irq_pin_primary_oe_out(p_oe),
      .irq_pin_secondary_in(s_pin), .irq_pin_secondary_out(s_out), .irq_pin_secondary_oe_out(s_oe),
      .trim_out(trim), .status1_out(st1), .status2_out(st2), .seconds_out(secs),
      .pin_level_out(lvl), .power_up_flag_out(flag));
   task automatic settle(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic wr_chk(input reg_sel_t sel, input logic [7:0] d, input logic [7:0] exp);
      host.write_reg(sel, d);
      settle(2);
      case (sel)
         SEL_TRIM: check(trim, exp);
         SEL_STATUS2: check(st2, exp);
         SEL_SECONDS: check({2'b00, secs}, exp);
         default: check(st1, exp);
      endcase
   endtask
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys_in);
      n_fail++;
      end_of_test();
   end
   initial begin
      settle(6);
      rst_n_in = 1'b1;
      settle(2);
      check(trim, 8'h00);
      check(st2, 8'h00);
      check(st1, 8'h01);
      check({7'h00, flag}, 8'h01);
      check({6'h00, lvl}, 8'h03);
      check(host.trim_fast(22, 1'b0), 8'h56);
      check(host.trim_slow(26, 1'b0), 8'hD8);
      foreach (codes[i]) wr_chk(SEL_TRIM, codes[i], codes[i]);
      wr_chk(SEL_TRIM, host.trim_fast(0, 1'b1), 8'h01);
      wr_chk(SEL_TRIM, 8'h00, 8'h00);
      wr_chk(SEL_STATUS2, 8'h07, 8'h07);
      settle(20);
      check({6'h00, s_oe, p_oe}, 8'h00);
      wr_chk(SEL_STATUS2, 8'h00, 8'h00);
      host.set_busy(1'b1);
      wr_chk(SEL_SECONDS, 8'h4B, 8'h00);
      host.set_busy(1'b0);
      wr_chk(SEL_SECONDS, 8'h3B, 8'h3B);
      for (cnt = 0; cnt < 40000 && p_oe !== 1'b1; cnt++) @(negedge clk_sys_in);
      check({7'h00, cnt >= 32700 && cnt <= 32850}, 8'h01);
      check({2'b00, secs}, 8'h3B);
      settle(4);
      check({6'h00, lvl}, 8'h02);
      wr_chk(SEL_STATUS1, 8'hFF, 8'h00);
      settle(3);
      check({6'h00, s_oe, p_oe}, 8'h00);
      // mode 2 on primary, mode 1 on secondary, with a time read open across the carry
      wr_chk(SEL_STATUS2, 8'h06, 8'h06);
      host.set_busy(1'b1);
      for (cnt = 0; cnt < 40000 && secs !== 6'h00; cnt++) @(negedge clk_sys_in);
      check({2'b00, secs}, 8'h00);
      settle(200);
      check({6'h00, s_oe, p_oe}, 8'h00);
      host.set_busy(1'b0);
      settle(4);
      check({6'h00, s_oe, p_oe}, 8'h03);
      // 128 stage ticks of four clocks each
      for (cnt = 0; cnt < 2000 && p_oe !== 1'b0; cnt++) @(negedge clk_sys_in);
      check({7'h00, cnt >= 500 && cnt <= 520}, 8'h01);
      check({6'h00, s_oe, p_oe}, 8'h02);
      wr_chk(SEL_STATUS2, 8'h02, 8'h02);
      check({6'h00, s_oe, p_oe}, 8'h00);
      wr_chk(SEL_STATUS2, 8'h06, 8'h06);
      check({6'h00, s_oe, p_oe}, 8'h02);
      end_of_test();
   end
endmodule
`default_nettype wire
